// file: core/ocft_pkg.sv
// ocft_pkg: constants and carrier types for the overcurrent and
// over-temperature fault logic.
// assumes a single 250 MHz clock domain; no bus, plain ports only.
package ocft_pkg;
  // clock and derived timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SAMPLE_DELAY_PS = 45000;   // comparator latch delay
  localparam int SAMPLE_WIN_PS = 60000;     // sampling window length
  // least time: round up
  localparam int SAMPLE_DELAY_CYC =
    (SAMPLE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest time: round down
  localparam int SAMPLE_WIN_CYC = SAMPLE_WIN_PS / CLK_PERIOD_PS;
  localparam int HICCUP_MS = 20;
  localparam int HICCUP_CYC = HICCUP_MS * 250000;  // 250 cycles per us
  // fault counting
  localparam logic [6:0] OC_HICCUP_DEFAULT = 7'h08;
  localparam logic [2:0] OC_CLEAN_RUN = 3'h6;
  localparam logic [1:0] OC_STEP_DOWN_RUN = 2'h3;
  localparam logic [2:0] OC_STEP_UP_RUN = 3'h4;
  localparam logic [6:0] OC_PBP_UNIT = 7'h08;
  // duty fractions in eighths of the period
  localparam logic [3:0] DUTY_HALF = 4'h4;
  localparam logic [3:0] DUTY_QUARTER = 4'h2;
  localparam logic [3:0] DUTY_EIGHTH = 4'h1;
  localparam logic [3:0] DUTY_FULL = 4'h8;
  // temperature
  localparam logic [7:0] OT_LIMIT_RESET = 8'h91;  // 145 C
  localparam logic [7:0] OT_HYST = 8'h19;         // 25 C
  // fast comparator thresholds per select-pin state (code units)
  localparam logic [7:0] OC_LIM_FLOAT = 8'h80;
  localparam logic [7:0] OC_LIM_HIGH = 8'hC0;
  localparam logic [7:0] OC_LIM_LOW = 8'h40;

  typedef enum logic [1:0] {
    OCFT_SEL_FLOAT, OCFT_SEL_HIGH, OCFT_SEL_LOW, OCFT_SEL_RSVD
  } ocft_sel_t;

  typedef enum logic [1:0] {
    OCFT_OC_HICCUP, OCFT_OC_PBP_LATCH, OCFT_OC_PBP_HICCUP, OCFT_OC_CC
  } ocft_oc_resp_t;

  typedef enum logic [1:0] {
    OCFT_OT_IGNORE, OCFT_OT_INHIBIT, OCFT_OT_LATCH, OCFT_OT_RSVD
  } ocft_ot_resp_t;

  // host configuration bundle
  typedef struct packed {
    logic analog_mode;
    ocft_oc_resp_t oc_resp;
    logic [2:0] pbp_eighths;   // count = (n+1)*8, 8..64
    logic oc_limit_override;
    logic [7:0] oc_limit;
    logic [11:0] oc_warn_limit;
    ocft_ot_resp_t ot_resp;
    logic ot_limit_override;
    logic [7:0] ot_limit;
  } ocft_cfg_t;

  // status bundle
  typedef struct packed {
    logic [11:0] iout;         // 1/16 A per lsb
    logic oc_warn;
    logic oc_fault;
    logic hiccup;
    logic oc_latched_off;
    logic [7:0] temp;          // 1 C per lsb
    logic ot_fault;
    logic ot_latched_off;
  } ocft_stat_t;
endpackage

// file: core/ocft_sampler.sv
// ocft_sampler: per-cycle overcurrent sampling window and latch.
// assumes cycle-start and drive-level inputs already synchronised.
module ocft_sampler
  import ocft_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic max_duty,
  input wire logic start_rise,
  input wire logic drive_rise,
  input wire logic comp,
  output logic sampled,
  output logic trip
);
  logic [4:0] cnt_q;
  logic armed_q;

  // delay counter starts on reference edge chosen by duty regime
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= 5'h00;
      armed_q <= 1'b0;
    end else if (max_duty ? drive_rise : start_rise) begin
      cnt_q <= 5'h00;
      armed_q <= 1'b1;
    end else if (armed_q) begin
      if (cnt_q == 5'(SAMPLE_WIN_CYC - 1))
        armed_q <= 1'b0;  // window closes after about 60 ns
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // latch the fast comparator 45 ns after the reference edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sampled <= 1'b0;
      trip <= 1'b0;
    end else begin
      sampled <= armed_q && cnt_q == 5'(SAMPLE_DELAY_CYC - 1);
      if (armed_q && cnt_q == 5'(SAMPLE_DELAY_CYC - 1))
        trip <= comp;
    end
  end
endmodule

// file: core/ocft_thermal.sv
// ocft_thermal: over-temperature trip, hysteresis and response.
// assumes temperature code already registered in this clock domain.
module ocft_thermal
  import ocft_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] temp,
  input wire logic [7:0] limit,
  input wire ocft_ot_resp_t resp,
  input wire logic clear_faults,
  output logic inhibit,
  output logic fault,
  output logic latched
);
  logic [7:0] release_lvl;

  assign release_lvl = (limit > OT_HYST) ? limit - OT_HYST : 8'h00;

  // trip above limit, release 25 C below it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault <= 1'b0;
    end else if (temp > limit) begin
      fault <= 1'b1;
    end else if (temp <= release_lvl) begin
      fault <= 1'b0;
    end
  end

  // latched response holds until clear; a new trip beats the clear
  always_ff @(posedge clk) begin
    if (!nrst)
      latched <= 1'b0;
    else if (resp == OCFT_OT_LATCH && temp > limit)
      latched <= 1'b1;
    else if (clear_faults)
      latched <= 1'b0;
  end

  always_comb begin
    case (resp)
      OCFT_OT_IGNORE: inhibit = latched;
      OCFT_OT_INHIBIT: inhibit = fault | latched;
      OCFT_OT_LATCH: inhibit = latched;
      default: inhibit = fault | latched;
    endcase
  end
endmodule

// file: core/ocft_core.sv
// ocft_core: overcurrent and over-temperature fault response for a
// synchronous buck stage: telemetry, warning, cycle counting, duty
// step-down/up, hiccup and latched shutdown.
// assumes pins from the power stage are asynchronous; host config
// and telemetry codes come from logic on the same clock.
//
// Functional notes
// - output current reported as average current code, 1/16 A lsb.
// - warning compares the reported current with host warn limit.
// - fault detection uses only the fast low-side comparator.
// - analog mode picks one of three limits from select pin state.
// - low-side switch turns off at falling edge of cycle start.
// - at max duty, latch comparator 45 ns after drive rises.
// - below max duty, latch 45 ns after cycle start rises.
// - default and analog mode hiccup after 8 limited cycles.
// - six clean cycles in a row clear the cycle counter.
// - hiccup holds enable low 20 ms, clears state, restarts.
// - pulse limiting for 8 to 64 cycles, then latch or hiccup.
// - host may override the overcurrent fault threshold.
// - duty at or below one eighth gets no reduction, only count.
// - three-cycle runs cut duty to half, quarter, eighth.
// - four clean cycles double limited duty back to nominal.
// - temperature reported with 1 C resolution.
// - over-temperature limit resets to 145 C.
// - default response inhibits conversion, auto restart; a zero ot_resp selects ignore, only analog mode forces inhibit.
// - restart uses 25 C hysteresis under the trip limit.
// - response ignore, inhibit or latch; limit programmable.
module ocft_core
  import ocft_pkg::*;
#(
  parameter int HICCUP_CYCLES = HICCUP_CYC
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycle_start_pulse,
  input wire logic low_drive_high,
  input wire logic overcurrent_trip,
  input wire logic sel_pin_high,
  input wire logic sel_pin_low,
  input wire logic max_duty,
  input wire logic [3:0] nominal_duty,
  input wire logic [11:0] avg_current_code,
  input wire logic [7:0] die_temp_code,
  input wire ocft_cfg_t cfg,
  input wire logic clear_faults,
  output logic low_side_switch,
  output logic conv_enable,
  output logic [3:0] duty_limit,
  output logic [7:0] oc_threshold,
  output logic host_alert_line_n,
  output ocft_stat_t status
);
  // synchronisers for power-stage pins
  logic [1:0] start_s_q, drive_s_q, comp_s_q, selh_s_q, sell_s_q;
  logic start_d1_q, drive_d1_q;
  logic start_rise, start_fall, drive_rise;
  logic sampled, trip;
  logic [6:0] oc_cnt_q;
  logic [2:0] clean_q;
  logic [1:0] run_dn_q;
  logic [2:0] run_up_q;
  logic [3:0] duty_q;
  logic limiting_q;
  logic hiccup_q;
  logic [22:0] hic_cnt_q;
  logic oc_latch_q;
  logic [6:0] oc_max;
  logic oc_reached;
  logic ot_inhibit, ot_fault, ot_latched;
  logic [7:0] ot_limit;
  logic oc_event_q;
  ocft_sel_t sel;

  // two flops before any logic reads a pin
  always_ff @(posedge clk) begin
    if (!nrst) begin
      start_s_q <= 2'h0;
      drive_s_q <= 2'h0;
      comp_s_q <= 2'h0;
      selh_s_q <= 2'h0;
      sell_s_q <= 2'h0;
    end else begin
      start_s_q <= {start_s_q[0], cycle_start_pulse};
      drive_s_q <= {drive_s_q[0], low_drive_high};
      comp_s_q <= {comp_s_q[0], overcurrent_trip};
      selh_s_q <= {selh_s_q[0], sel_pin_high};
      sell_s_q <= {sell_s_q[0], sel_pin_low};
    end
  end

  // edge detection on synchronised levels only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      start_d1_q <= 1'b0;
      drive_d1_q <= 1'b0;
    end else begin
      start_d1_q <= start_s_q[1];
      drive_d1_q <= drive_s_q[1];
    end
  end

  assign start_rise = start_s_q[1] & ~start_d1_q;
  assign start_fall = ~start_s_q[1] & start_d1_q;
  assign drive_rise = drive_s_q[1] & ~drive_d1_q;

  // low-side switch on from drive onset, off at cycle-start fall
  always_ff @(posedge clk) begin
    if (!nrst)
      low_side_switch <= 1'b0;
    else if (!conv_enable || start_fall)
      low_side_switch <= 1'b0;
    else if (drive_rise)
      low_side_switch <= 1'b1;
  end

  ocft_sampler u_sampler (
    .clk(clk),
    .nrst(nrst),
    .max_duty(max_duty),
    .start_rise(start_rise),
    .drive_rise(drive_rise),
    .comp(comp_s_q[1]),
    .sampled(sampled),
    .trip(trip)
  );

  // fault threshold: analog pin choice or host override
  always_comb begin
    if (selh_s_q[1])
      sel = OCFT_SEL_HIGH;
    else if (sell_s_q[1])
      sel = OCFT_SEL_LOW;
    else
      sel = OCFT_SEL_FLOAT;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      oc_threshold <= OC_LIM_FLOAT;
    else if (!cfg.analog_mode && cfg.oc_limit_override)
      oc_threshold <= cfg.oc_limit;
    else begin
      case (sel)
        OCFT_SEL_HIGH: oc_threshold <= OC_LIM_HIGH;
        OCFT_SEL_LOW: oc_threshold <= OC_LIM_LOW;
        default: oc_threshold <= OC_LIM_FLOAT;
      endcase
    end
  end

  // count limit depends on configured response
  assign oc_max = (cfg.analog_mode || cfg.oc_resp == OCFT_OC_HICCUP)
    ? OC_HICCUP_DEFAULT
    : 7'({4'h0, cfg.pbp_eighths} + 7'h01) * OC_PBP_UNIT;
  assign oc_reached = oc_cnt_q >= oc_max;

  // one decision per sample, so one count per switching cycle
  always_ff @(posedge clk) begin
    if (!nrst || hiccup_q || oc_latch_q) begin
      oc_cnt_q <= 7'h00;
      clean_q <= 3'h0;
    end else if (sampled) begin
      if (trip) begin
        clean_q <= 3'h0;
        if (!oc_reached)
          oc_cnt_q <= oc_cnt_q + 7'h01;
      end else if (clean_q == OC_CLEAN_RUN - 3'h1) begin
        clean_q <= 3'h0;
        oc_cnt_q <= 7'h00;
      end else
        clean_q <= clean_q + 3'h1;
    end
  end

  // constant-current duty stepping in eighths of the period
  always_ff @(posedge clk) begin
    if (!nrst || hiccup_q || oc_latch_q) begin
      duty_q <= DUTY_FULL;
      limiting_q <= 1'b0;
      run_dn_q <= 2'h0;
      run_up_q <= 3'h0;
    end else if (sampled && cfg.oc_resp == OCFT_OC_CC
                 && !cfg.analog_mode) begin
      if (trip) begin
        run_up_q <= 3'h0;
        if (!limiting_q && nominal_duty <= DUTY_EIGHTH) begin
          run_dn_q <= 2'h0;
        end else if (run_dn_q == OC_STEP_DOWN_RUN - 2'h1) begin
          run_dn_q <= 2'h0;
          limiting_q <= 1'b1;
          if (!limiting_q)
            duty_q <= DUTY_HALF;
          else if (duty_q > DUTY_EIGHTH)
            duty_q <= duty_q >> 1;
        end else
          run_dn_q <= run_dn_q + 2'h1;
      end else begin
        run_dn_q <= 2'h0;
        if (!limiting_q)
          run_up_q <= 3'h0;
        else if (run_up_q == OC_STEP_UP_RUN - 3'h1) begin
          run_up_q <= 3'h0;
          if (duty_q >= DUTY_HALF)
            limiting_q <= 1'b0;
          else
            duty_q <= duty_q << 1;
        end else
          run_up_q <= run_up_q + 3'h1;
      end
    end
  end

  assign duty_limit = limiting_q ? duty_q : DUTY_FULL;

  // hiccup timer: enable low for the full hold, then restart
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hiccup_q <= 1'b0;
      hic_cnt_q <= 23'h000000;
    end else if (hiccup_q) begin
      if (hic_cnt_q == 23'(HICCUP_CYCLES - 1)) begin
        hiccup_q <= 1'b0;
        hic_cnt_q <= 23'h000000;
      end else
        hic_cnt_q <= hic_cnt_q + 23'h000001;
    end else if (oc_reached && !oc_latch_q
                 && (cfg.analog_mode || cfg.oc_resp != OCFT_OC_PBP_LATCH))
      hiccup_q <= 1'b1;
  end

  // latched shutdown until host clears faults; trip beats clear
  always_ff @(posedge clk) begin
    if (!nrst)
      oc_latch_q <= 1'b0;
    else if (oc_reached && !cfg.analog_mode
             && cfg.oc_resp == OCFT_OC_PBP_LATCH)
      oc_latch_q <= 1'b1;
    else if (clear_faults)
      oc_latch_q <= 1'b0;
  end

  // sticky fault event for status and alert
  always_ff @(posedge clk) begin
    if (!nrst)
      oc_event_q <= 1'b0;
    else if (oc_reached)
      oc_event_q <= 1'b1;
    else if (clear_faults)
      oc_event_q <= 1'b0;
  end

  assign ot_limit = (!cfg.analog_mode && cfg.ot_limit_override)
    ? cfg.ot_limit : OT_LIMIT_RESET;

  ocft_thermal u_thermal (
    .clk(clk),
    .nrst(nrst),
    .temp(status.temp),
    .limit(ot_limit),
    .resp(cfg.analog_mode ? OCFT_OT_INHIBIT : cfg.ot_resp),
    .clear_faults(clear_faults),
    .inhibit(ot_inhibit),
    .fault(ot_fault),
    .latched(ot_latched)
  );

  // conversion enable gathers every shutdown cause
  always_ff @(posedge clk) begin
    if (!nrst)
      conv_enable <= 1'b0;
    else
      conv_enable <= !hiccup_q && !oc_latch_q && !ot_inhibit;
  end

  // telemetry and status registers
  always_ff @(posedge clk) begin
    if (!nrst)
      status <= '0;
    else begin
      status.iout <= avg_current_code;
      status.oc_warn <= avg_current_code > cfg.oc_warn_limit;
      status.oc_fault <= oc_event_q;
      status.hiccup <= hiccup_q;
      status.oc_latched_off <= oc_latch_q;
      status.temp <= die_temp_code;
      status.ot_fault <= ot_fault;
      status.ot_latched_off <= ot_latched;
    end
  end

  // alert stays low while any fault is recorded
  always_ff @(posedge clk) begin
    if (!nrst)
      host_alert_line_n <= 1'b1;
    else
      host_alert_line_n <= !(oc_event_q || status.oc_warn || ot_fault
                             || ot_latched);
  end
endmodule

// file: bench/ocft_stage_model.sv
// ocft_stage_model: power stage side of the fault logic: cycle start
// pulse, low-side drive level and the fast valley comparator.
// assumes clk is the fault logic clock; pins move on its falling edge.
module ocft_stage_model #(
  parameter int PERIOD = 64
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic oc_en,
  output logic cycle_start_pulse,
  output logic low_drive_high,
  output logic overcurrent_trip,
  output logic at_start
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // position in the switching cycle; restarts with reset
  always @(negedge clk) begin
    cnt = (!nrst || cnt == PERIOD - 1) ? 0 : cnt + 1;
    cycle_start_pulse <= cnt < PERIOD / 8;
    low_drive_high <= cnt > PERIOD / 8 && cnt < PERIOD - 4;
    overcurrent_trip <= oc_en;
  end
  // lets the bench line up oc changes with cycle boundaries
  assign at_start = cnt == 0;
endmodule

// file: bench/ocft_core_properties.sv
// ocft_core_properties: port-level checks of the fault logic.
// assumes one clock domain; bound to ocft_core, sees its ports only.
module ocft_core_properties
  import ocft_pkg::*;
#(
  parameter int HICCUP_CYCLES = 50
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycle_start_pulse,
  input wire logic sel_pin_high,
  input wire logic sel_pin_low,
  input wire logic [3:0] nominal_duty,
  input wire logic [11:0] avg_current_code,
  input wire logic [7:0] die_temp_code,
  input wire ocft_cfg_t cfg,
  input wire logic clear_faults,
  input wire logic low_side_switch,
  input wire logic conv_enable,
  input wire logic [3:0] duty_limit,
  input wire logic [7:0] oc_threshold,
  input wire ocft_stat_t status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [15:0] lo_q;
  logic hic_q;
  // length of an enable-low stretch, and whether hiccup caused it
  always_ff @(posedge clk) begin
    if (!nrst || conv_enable) begin
      lo_q <= 16'h0000;
      hic_q <= 1'b0;
    end else begin
      lo_q <= lo_q + 16'h0001;
      hic_q <= hic_q | status.hiccup;
    end
  end
  // pin level settled long enough to pass the synchronisers
  sequence s_float;
    cfg.analog_mode && !sel_pin_high && !sel_pin_low;
  endsequence
  sequence s_hot;
    die_temp_code > OT_LIMIT_RESET && !cfg.ot_limit_override &&
      cfg.ot_resp == OCFT_OT_INHIBIT;
  endsequence
  thr_float_a: assert property (s_float [*6] |->
    oc_threshold == OC_LIM_FLOAT) else $error("float limit wrong");
  thr_high_a: assert property ((cfg.analog_mode && sel_pin_high &&
    !sel_pin_low) [*6] |-> oc_threshold == OC_LIM_HIGH)
    else $error("high limit wrong");
  thr_host_a: assert property ((!cfg.analog_mode &&
    cfg.oc_limit_override && $stable(cfg.oc_limit)) [*6] |->
    oc_threshold == cfg.oc_limit) else $error("host limit ignored");
  iout_rep_a: assert property ($stable(avg_current_code) [*3] |->
    status.iout == avg_current_code) else $error("iout wrong");
  warn_cmp_a: assert property (($stable(avg_current_code) &&
    $stable(cfg.oc_warn_limit)) [*3] |->
    status.oc_warn == (avg_current_code > cfg.oc_warn_limit))
    else $error("warning wrong");
  temp_rep_a: assert property ($stable(die_temp_code) [*4] |->
    status.temp == die_temp_code) else $error("temp wrong");
  hot_inhib_a: assert property (s_hot [*5] |-> !conv_enable)
    else $error("no thermal inhibit");
  hyst_hold_a: assert property ((status.ot_fault && !clear_faults &&
    !cfg.ot_limit_override &&
    die_temp_code > OT_LIMIT_RESET - OT_HYST) [*3] |=> status.ot_fault)
    else $error("thermal fault left early");
  sw_off_a: assert property ($fell(cycle_start_pulse) |->
    ##[1:5] !low_side_switch) else $error("low side stays on");
  duty_step_a: assert property ($changed(duty_limit) |->
    duty_limit == DUTY_FULL || duty_limit == $past(duty_limit) >> 1 ||
    duty_limit == $past(duty_limit) << 1) else $error("bad duty step");
  low_duty_a: assert property ((nominal_duty <= DUTY_EIGHTH &&
    duty_limit == DUTY_FULL) ##1 nominal_duty <= DUTY_EIGHTH |->
    duty_limit == DUTY_FULL) else $error("low duty was cut");
  hic_len_a: assert property ($rose(conv_enable) && hic_q |->
    lo_q >= HICCUP_CYCLES) else $error("hiccup too short");
endmodule

bind ocft_core ocft_core_properties #(
  .HICCUP_CYCLES(HICCUP_CYCLES)
) u_ocft_core_properties (
  .clk(clk), .nrst(nrst), .cycle_start_pulse(cycle_start_pulse),
  .sel_pin_high(sel_pin_high), .sel_pin_low(sel_pin_low),
  .nominal_duty(nominal_duty), .avg_current_code(avg_current_code),
  .die_temp_code(die_temp_code), .cfg(cfg), .clear_faults(clear_faults),
  .low_side_switch(low_side_switch), .conv_enable(conv_enable),
  .duty_limit(duty_limit), .oc_threshold(oc_threshold), .status(status)
);

// file: bench/ocft_core_tb.sv
// ocft_core_tb: self-checking bench for the fault logic.
// assumes the stage model drives the pins; host side driven here.
module ocft_core_tb
  import ocft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HC = 50;
  localparam int P = 64;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic oc_en = 1'b0;
  logic sel_h = 1'b0;
  logic sel_l = 1'b0;
  logic max_duty = 1'b0;
  logic clear_faults = 1'b0;
  logic [3:0] nom = 4'h8;
  logic [11:0] avg = 12'h000;
  logic [7:0] temp = 8'h19;
  ocft_cfg_t cfg = '0;
  logic csp, ldh, oct, start, lss, conv, alert_n;
  logic [3:0] dlim;
  logic [7:0] thr;
  ocft_stat_t stat;
  int error_cnt = 0;
  int num_checks = 0;
  // 4 ns period
  always #2 clk = ~clk;
  ocft_core #(.HICCUP_CYCLES(HC)) u_ocft_core (
    .clk(clk), .nrst(nrst), .cycle_start_pulse(csp),
    .low_drive_high(ldh), .overcurrent_trip(oct),
    .sel_pin_high(sel_h), .sel_pin_low(sel_l), .max_duty(max_duty),
    .nominal_duty(nom), .avg_current_code(avg), .die_temp_code(temp),
    .cfg(cfg), .clear_faults(clear_faults), .low_side_switch(lss),
    .conv_enable(conv), .duty_limit(dlim), .oc_threshold(thr),
    .host_alert_line_n(alert_n), .status(stat)
  );
  ocft_stage_model #(.PERIOD(P)) u_ocft_stage_model (
    .clk(clk), .nrst(nrst), .oc_en(oc_en), .cycle_start_pulse(csp),
    .low_drive_high(ldh), .overcurrent_trip(oct), .at_start(start)
  );
  // shared compare, verdict and timing helpers
  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task need(input logic ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("timeout at %0t", $time);
      wrap_up();
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task rst();
    nrst = 1'b0;
    cfg = '0;
    avg = 12'h000;  // stale current would hold the warning and alert
    oc_en <= 1'b0;
    tick(4);
    nrst = 1'b1;
    tick(2);
  endtask
  // n whole switching cycles, oc set just after the cycle starts
  task sw(input int n, input logic oc);
    @(posedge clk);
    repeat (P) if (start !== 1'b1) @(posedge clk);
    need(start);
    @(negedge clk);
    oc_en <= oc;
    tick(n * P - 1);
  endtask
  task wait_conv(input logic lvl, input int lim, output int n);
    n = 0;
    while (conv !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    need(conv === lvl);
  endtask
  task t_reset();
    tick(12);
    chk(conv, 1'b0);
    chk(alert_n, 1'b1);
    chk(dlim, DUTY_FULL);
    chk(thr, OC_LIM_FLOAT);
    chk(stat === '0, 1'b1);
    nrst = 1'b1;
    tick(2);
    chk(conv, 1'b1);
    $display("reset done");
  endtask
  task t_telem();
    avg = 12'h123;
    temp = 8'h55;
    cfg.oc_warn_limit = 12'h122;
    tick(6);
    chk(stat.iout, 12'h123);
    chk(stat.temp, 8'h55);
    chk(stat.oc_warn, 1'b1);
    cfg.oc_warn_limit = 12'h123;
    tick(6);
    chk(stat.oc_warn, 1'b0);
    $display("telemetry done");
  endtask
  task t_limit();
    logic [7:0] e [3];
    e = '{OC_LIM_FLOAT, OC_LIM_HIGH, OC_LIM_LOW};
    cfg.analog_mode = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {sel_l, sel_h} = 2'(i);
      tick(8);
      chk(thr, e[i]);
    end
    {sel_l, sel_h} = 2'b00;
    cfg = '0;
    cfg.oc_limit_override = 1'b1;
    cfg.oc_limit = 8'h5A;
    tick(8);
    chk(thr, 8'h5A);
    $display("limits done");
  endtask
  // overload that never clears: hiccup, restart, hiccup again
  task t_hiccup();
    int n;
    rst();
    cfg.analog_mode = 1'b1;
    nom = DUTY_EIGHTH;
    sw(7, 1'b1);
    chk(conv, 1'b1);
    chk(dlim, DUTY_FULL);
    wait_conv(1'b0, 2 * P, n);
    chk(stat.hiccup, 1'b1);
    wait_conv(1'b1, HC + 8, n);
    chk(n >= HC && n <= HC + 3, 1'b1);
    wait_conv(1'b0, 9 * P, n);
    chk(n > 6 * P, 1'b1);
    nom = DUTY_FULL;
    $display("hiccup done");
  endtask
  task t_clean();
    rst();
    cfg.analog_mode = 1'b1;
    sw(7, 1'b1);
    avg = 12'hFFF;
    sw(6, 1'b0);
    sw(7, 1'b1);
    chk(conv, 1'b1);
    sw(1, 1'b1);
    chk(conv, 1'b0);
    $display("clean run done");
  endtask
  task t_cc();
    logic [3:0] e [6];
    e = '{DUTY_HALF, DUTY_QUARTER, DUTY_EIGHTH,
      DUTY_QUARTER, DUTY_HALF, DUTY_FULL};
    rst();
    cfg.oc_resp = OCFT_OC_CC;
    cfg.pbp_eighths = 3'h1;
    // low duty in digital mode: cycles counted, no cut
    nom = DUTY_EIGHTH;
    sw(3, 1'b1);
    chk(dlim, DUTY_FULL);
    nom = DUTY_FULL;
    for (int i = 0; i < 6; i++) begin
      sw(i < 3 ? 3 : 4, i < 3);
      chk(dlim, e[i]);
    end
    sw(15, 1'b1);
    chk(dlim, DUTY_EIGHTH);
    chk(conv, 1'b1);
    sw(1, 1'b1);
    chk(conv, 1'b0);
    $display("constant current done");
  endtask
  task t_latch();
    int n;
    rst();
    cfg.oc_resp = OCFT_OC_PBP_LATCH;
    max_duty = 1'b1;
    sw(7, 1'b1);
    chk(conv, 1'b1);
    sw(3, 1'b1);
    chk(conv, 1'b0);
    chk(stat.oc_latched_off, 1'b1);
    chk(lss, 1'b0);
    chk(stat.oc_fault, 1'b1);
    chk(alert_n, 1'b0);
    sw(1, 1'b0);
    clear_faults = 1'b1;
    tick(1);
    clear_faults = 1'b0;
    tick(4);
    chk(conv, 1'b1);
    chk(alert_n, 1'b1);
    max_duty = 1'b0;
    cfg.oc_resp = OCFT_OC_PBP_HICCUP;
    cfg.pbp_eighths = 3'h1;
    sw(15, 1'b1);
    chk(conv, 1'b1);
    wait_conv(1'b0, P, n);
    chk(stat.oc_latched_off, 1'b0);
    $display("pulse limit done");
  endtask
  task tset(input logic [7:0] t, input logic e);
    temp = t;
    tick(8);
    chk(conv, e);
  endtask
  task t_therm();
    rst();
    cfg.ot_resp = OCFT_OT_INHIBIT;
    tset(8'h91, 1'b1);
    tset(8'h92, 1'b0);
    chk(stat.ot_fault, 1'b1);
    tset(8'h79, 1'b0);
    tset(8'h78, 1'b1);
    cfg.ot_resp = OCFT_OT_IGNORE;
    tset(8'hC8, 1'b1);
    cfg.ot_resp = OCFT_OT_LATCH;
    tset(8'hC8, 1'b0);
    chk(stat.ot_latched_off, 1'b1);
    tset(8'h20, 1'b0);
    clear_faults = 1'b1;
    tick(1);
    clear_faults = 1'b0;
    tset(8'h20, 1'b1);
    cfg.ot_resp = OCFT_OT_INHIBIT;
    cfg.ot_limit_override = 1'b1;
    cfg.ot_limit = 8'h64;
    tset(8'h65, 1'b0);
    tset(8'h4C, 1'b0);
    tset(8'h4B, 1'b1);
    $display("thermal done");
  endtask
  // main sequence; every wait inside is bounded
  initial begin
    t_reset();
    t_telem();
    t_limit();
    t_hiccup();
    t_clean();
    t_cc();
    t_latch();
    t_therm();
    wrap_up();
  end
endmodule
